// File: core/putc_defines.svh
// Command codes, field positions, reset values and timing constants of the config bank
`ifndef PUTC_DEFINES_SVH
`define PUTC_DEFINES_SVH

// Command codes on the management bus
`define PUTC_CMD_UNUSED_PINS 8'hC5
`define PUTC_CMD_REMOTE_LEVEL 8'hC6
`define PUTC_CMD_KICK_LEAD 8'hC7
`define PUTC_CMD_FAST_OFF 8'hC8
`define PUTC_CMD_PGOOD_POL 8'hD0

// Transfer lengths in bytes
`define PUTC_LEN_NONE 2'h0
`define PUTC_LEN_BYTE 2'h1
`define PUTC_LEN_WORD 2'h2

// Unused-pin word layout
`define PUTC_PIN_CNT 8
`define PUTC_UTIL_LSB 0
`define PUTC_DIR_LSB 8

// Bit position of each auxiliary pin inside either byte half
`define PUTC_PIN_SECOND_FAULT 7
`define PUTC_PIN_TEST_MODE_SEL 6
`define PUTC_PIN_TEST_DATA_IN 5
`define PUTC_PIN_TEST_DATA_OUT 4
`define PUTC_PIN_PWM3_CHB 3
`define PUTC_PIN_PWM3_CHA 2
`define PUTC_PIN_PWM2_CHB 1
`define PUTC_PIN_EXT_ADC_TRIG 0

// Reset values
`define PUTC_RST_UNUSED_PINS 16'h0000
`define PUTC_RST_REMOTE_LEVEL 8'h00
`define PUTC_RST_KICK_LEAD 8'h00
`define PUTC_RST_FAST_OFF 8'h00
`define PUTC_RST_PGOOD_POL 8'h00

// Power-good polarity: bit that selects active high
`define PUTC_PGOOD_HIGH_BIT 0

// Value returned for bytes past the end of a register
`define PUTC_RD_FILL 8'hFF

// Default 7-bit bus address
`define PUTC_BUS_ADDR 7'h2A

// Kickstart lead time
`define PUTC_CLK_PERIOD_NS 100
`define PUTC_KICK_BASE_NS 20000
`define PUTC_KICK_STEP_NS 450
`define PUTC_KICK_CYC_W 11

`endif

// File: core/putc_pkg.sv
// Types shared by the config bank
package putc_pkg;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_CMD = 7'h04,
		ST_WDATA = 7'h08,
		ST_RSTART = 7'h10,
		ST_RDATA = 7'h20,
		ST_IGNORE = 7'h40
	} putc_state_t;

endpackage : putc_pkg

// File: core/putc_smb_phy.sv
// Bit level engine of the management bus: start, stop, byte shift, ack and read drive
module putc_smb_phy (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic ack_en,
	input wire logic tx_en,
	input wire logic [7:0] tx_byte,
	output logic start_p,
	output logic stop_p,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic ack_p,
	output logic acked,
	output logic sda_oe
);
	import putc_pkg::*;

	logic scl_q;
	logic sda_q;
	logic act_r;
	logic [3:0] cnt_r;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic bit_rise;
	logic last_data;
	logic ack_slot;
	logic act_nxt;
	logic [3:0] cnt_nxt;
	logic [7:0] shf_nxt;
	logic tx_bit_low;
	logic oe_nxt;

	assign scl_rise = scl_in & ~scl_q;
	assign scl_fall = ~scl_in & scl_q;
	// Data may only move while SCL is low, so an SDA edge under a high SCL is framing
	assign start_det = scl_in & scl_q & sda_q & ~sda_in;
	assign stop_det = scl_in & scl_q & ~sda_q & sda_in;
	assign bit_rise = act_r & scl_rise;
	assign last_data = (cnt_r == 4'h7);
	assign ack_slot = (cnt_r == 4'h8);
	assign act_nxt = start_det ? 1'b1 : (stop_det ? 1'b0 : act_r);
	assign cnt_nxt = start_det ? 4'h0 : (bit_rise ? (ack_slot ? 4'h0 : cnt_r + 4'h1) : cnt_r);
	assign shf_nxt = (bit_rise & ~ack_slot) ? {rx_byte[6:0], sda_in} : rx_byte;
	assign tx_bit_low = tx_en & ~tx_byte[3'h7 - cnt_r[2:0]];
	// Drive changes only after a falling SCL; framing always releases the line
	assign oe_nxt = (start_det | stop_det) ? 1'b0 :
		((act_r & scl_fall) ? (ack_slot ? ack_en : tx_bit_low) : sda_oe);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			act_r <= 1'b0;
			cnt_r <= 4'h0;
			rx_byte <= 8'h00;
			sda_oe <= 1'b0;
			start_p <= 1'b0;
			stop_p <= 1'b0;
			rx_valid <= 1'b0;
			ack_p <= 1'b0;
			acked <= 1'b0;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			act_r <= act_nxt;
			cnt_r <= cnt_nxt;
			rx_byte <= shf_nxt;
			sda_oe <= oe_nxt;
			start_p <= start_det;
			stop_p <= stop_det;
			rx_valid <= bit_rise & last_data;
			ack_p <= bit_rise & ack_slot;
			acked <= bit_rise & ack_slot ? ~sda_in : acked;
		end
	end

endmodule : putc_smb_phy

// File: core/putc_top.sv
// Unused-pin and threshold configuration bank behind the management serial bus
//
// Function
// - Low byte: per-pin flag, 1 means unused
// - Unused flag overrides all other pin settings
// - High byte: unused pin input or drive low
// - Unused input pins grounded externally, else output
// - Both bytes share one fixed pin order
// - Byte register holds remote-control trip level
// - Kickstart lead 20us plus 450ns per code
// - Byte offset added to input-off shutdown level
// - Polarity byte: zero low, one high active
// - Pin config uses words, others use bytes
`include "putc_defines.svh"

module putc_top #(
	parameter logic [6:0] BUS_ADDR = `PUTC_BUS_ADDR
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic [7:0] AUX_IN,
	input wire logic [7:0] FUNC_OUT,
	input wire logic [7:0] FUNC_OE,
	output logic [7:0] AUX_OUT,
	output logic [7:0] AUX_OE,
	output logic [7:0] FUNC_IN,
	output logic [7:0] PIN_UNUSED,
	output logic [7:0] REMOTE_LEVEL,
	output logic [7:0] KICK_LEAD_CODE,
	output logic [`PUTC_KICK_CYC_W-1:0] KICK_LEAD_CYC,
	output logic [7:0] FAST_OFF_OFFSET,
	input wire logic PGOOD_STATE,
	output logic PGOOD_PIN
);
	import putc_pkg::*;

	putc_state_t state_r;
	putc_state_t state_nxt;
	logic ack_en_r;
	logic ack_en_nxt;
	logic tx_en_r;
	logic tx_en_nxt;
	logic [7:0] tx_byte_r;
	logic [7:0] tx_byte_nxt;
	logic [7:0] cmd_r;
	logic [7:0] cmd_nxt;
	logic [1:0] wr_cnt_r;
	logic [1:0] wr_cnt_nxt;
	logic [1:0] rd_idx_r;
	logic [1:0] rd_idx_nxt;
	logic [7:0] wb0_r;
	logic [7:0] wb0_nxt;
	logic [7:0] wb1_r;
	logic [7:0] wb1_nxt;
	logic rd_ok_r;
	logic rd_ok_nxt;

	logic [15:0] pins_r;
	logic [15:0] pins_nxt;
	logic [7:0] rlev_r;
	logic [7:0] rlev_nxt;
	logic [7:0] kick_r;
	logic [7:0] kick_nxt;
	logic [7:0] foff_r;
	logic [7:0] foff_nxt;
	logic [7:0] pgpol_r;
	logic [7:0] pgpol_nxt;

	logic start_p;
	logic stop_p;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic ack_p;
	logic acked;
	logic phy_oe;

	logic addr_hit;
	logic rd_dir;
	logic [1:0] rx_len;
	logic [1:0] cur_len;
	logic [1:0] rd_idx_inc;
	logic commit;
	logic [7:0] util;
	logic [7:0] dir;
	logic [7:0] aux_out_nxt;
	logic [7:0] aux_oe_nxt;
	logic [7:0] func_in_nxt;
	logic [`PUTC_KICK_CYC_W-1:0] kick_cyc_nxt;
	logic pgood_nxt;

	// Transfer length of each command; zero marks a command this bank does not own
	function automatic logic [1:0] cmd_len(input logic [7:0] cmd);
		case (cmd)
			`PUTC_CMD_UNUSED_PINS: cmd_len = `PUTC_LEN_WORD;
			`PUTC_CMD_REMOTE_LEVEL,
			`PUTC_CMD_KICK_LEAD,
			`PUTC_CMD_FAST_OFF,
			`PUTC_CMD_PGOOD_POL: cmd_len = `PUTC_LEN_BYTE;
			default: cmd_len = `PUTC_LEN_NONE;
		endcase
	endfunction : cmd_len

	// Read data, low byte first; bytes past the register length read as fill
	function automatic logic [7:0] rd_byte(input logic [7:0] cmd, input logic [1:0] idx);
		logic [7:0] val;
		val = `PUTC_RD_FILL;
		if (idx < cmd_len(cmd)) begin
			case (cmd)
				`PUTC_CMD_UNUSED_PINS: val = (idx == 2'h0) ? pins_r[7:0] : pins_r[15:8];
				`PUTC_CMD_REMOTE_LEVEL: val = rlev_r;
				`PUTC_CMD_KICK_LEAD: val = kick_r;
				`PUTC_CMD_FAST_OFF: val = foff_r;
				`PUTC_CMD_PGOOD_POL: val = pgpol_r;
				default: val = `PUTC_RD_FILL;
			endcase
		end
		rd_byte = val;
	endfunction : rd_byte

	putc_smb_phy u_phy (
		.clk(CLK),
		.rst_n(RSTN),
		.scl_in(SCL_IN),
		.sda_in(SDA_IN),
		.ack_en(ack_en_r),
		.tx_en(tx_en_r),
		.tx_byte(tx_byte_r),
		.start_p(start_p),
		.stop_p(stop_p),
		.rx_valid(rx_valid),
		.rx_byte(rx_byte),
		.ack_p(ack_p),
		.acked(acked),
		.sda_oe(phy_oe)
	);

	assign SDA_OE = phy_oe;
	assign addr_hit = (rx_byte[7:1] == BUS_ADDR);
	assign rd_dir = rx_byte[0];
	assign rx_len = cmd_len(rx_byte);
	assign cur_len = cmd_len(cmd_r);
	assign rd_idx_inc = (rd_idx_r == 2'h3) ? rd_idx_r : rd_idx_r + 2'h1;

	// Transaction sequencer
	always_comb begin
		state_nxt = state_r;
		ack_en_nxt = ack_en_r;
		tx_en_nxt = tx_en_r;
		tx_byte_nxt = tx_byte_r;
		cmd_nxt = cmd_r;
		wr_cnt_nxt = wr_cnt_r;
		rd_idx_nxt = rd_idx_r;
		wb0_nxt = wb0_r;
		wb1_nxt = wb1_r;
		rd_ok_nxt = rd_ok_r;
		if (start_p) begin
			state_nxt = ST_ADDR;
			ack_en_nxt = 1'b0;
			tx_en_nxt = 1'b0;
			// A read is only legal after a command byte with no data behind it
			rd_ok_nxt = (state_r == ST_WDATA) && (wr_cnt_r == 2'h0);
		end else if (stop_p) begin
			state_nxt = ST_IDLE;
			ack_en_nxt = 1'b0;
			tx_en_nxt = 1'b0;
			rd_ok_nxt = 1'b0;
		end else if (ack_p) begin
			ack_en_nxt = 1'b0;
			case (state_r)
				ST_RSTART: begin
					state_nxt = ST_RDATA;
				end
				ST_RDATA: begin
					if (acked) begin
						rd_idx_nxt = rd_idx_inc;
						tx_byte_nxt = rd_byte(cmd_r, rd_idx_inc);
					end else begin
						tx_en_nxt = 1'b0;
						state_nxt = ST_IGNORE;
					end
				end
				default: begin
				end
			endcase
		end else if (rx_valid) begin
			case (state_r)
				ST_ADDR: begin
					if (!addr_hit) begin
						state_nxt = ST_IGNORE;
					end else if (!rd_dir) begin
						state_nxt = ST_CMD;
						ack_en_nxt = 1'b1;
					end else if (rd_ok_r) begin
						state_nxt = ST_RSTART;
						ack_en_nxt = 1'b1;
						tx_en_nxt = 1'b1;
						rd_idx_nxt = 2'h0;
						tx_byte_nxt = rd_byte(cmd_r, 2'h0);
					end else begin
						state_nxt = ST_IGNORE;
					end
				end
				ST_CMD: begin
					if (rx_len != `PUTC_LEN_NONE) begin
						cmd_nxt = rx_byte;
						wr_cnt_nxt = 2'h0;
						ack_en_nxt = 1'b1;
						state_nxt = ST_WDATA;
					end else begin
						state_nxt = ST_IGNORE;
					end
				end
				ST_WDATA: begin
					// Surplus bytes are refused so a malformed write never commits
					if (wr_cnt_r < cur_len) begin
						if (wr_cnt_r == 2'h0) begin
							wb0_nxt = rx_byte;
						end else begin
							wb1_nxt = rx_byte;
						end
						wr_cnt_nxt = wr_cnt_r + 2'h1;
						ack_en_nxt = 1'b1;
					end else begin
						state_nxt = ST_IGNORE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Writes take effect only at a stop with exactly the right byte count
	assign commit = stop_p && (state_r == ST_WDATA) && (wr_cnt_r == cur_len)
		&& (cur_len != `PUTC_LEN_NONE);
	assign pins_nxt = (commit && cmd_r == `PUTC_CMD_UNUSED_PINS) ? {wb1_r, wb0_r} : pins_r;
	assign rlev_nxt = (commit && cmd_r == `PUTC_CMD_REMOTE_LEVEL) ? wb0_r : rlev_r;
	assign kick_nxt = (commit && cmd_r == `PUTC_CMD_KICK_LEAD) ? wb0_r : kick_r;
	assign foff_nxt = (commit && cmd_r == `PUTC_CMD_FAST_OFF) ? wb0_r : foff_r;
	assign pgpol_nxt = (commit && cmd_r == `PUTC_CMD_PGOOD_POL) ? wb0_r : pgpol_r;

	assign util = pins_r[`PUTC_UTIL_LSB +: `PUTC_PIN_CNT];
	assign dir = pins_r[`PUTC_DIR_LSB +: `PUTC_PIN_CNT];

	// Same bit index in both halves names the same pin
	genvar gi;
	generate
		for (gi = 0; gi < `PUTC_PIN_CNT; gi = gi + 1) begin : g_pin
			// Unused pin never passes its function through, whatever else asks
			assign aux_oe_nxt[gi] = util[gi] ? dir[gi] : FUNC_OE[gi];
			// An unused output only ever pulls low; an unused input floats to board ground
			assign aux_out_nxt[gi] = util[gi] ? 1'b0 : FUNC_OUT[gi];
			assign func_in_nxt[gi] = util[gi] ? 1'b0 : AUX_IN[gi];
		end
	endgenerate

	// Lead time in clock cycles, rounded down
	assign kick_cyc_nxt = `PUTC_KICK_CYC_W'((32'(kick_r) * `PUTC_KICK_STEP_NS
		+ `PUTC_KICK_BASE_NS) / `PUTC_CLK_PERIOD_NS);
	// Any code with bit 0 clear leaves the output active low; bit 0 set makes it active high
	assign pgood_nxt = pgpol_r[`PUTC_PGOOD_HIGH_BIT] ? PGOOD_STATE : ~PGOOD_STATE;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= ST_IDLE;
			ack_en_r <= 1'b0;
			tx_en_r <= 1'b0;
			tx_byte_r <= 8'h00;
			cmd_r <= 8'h00;
			wr_cnt_r <= 2'h0;
			rd_idx_r <= 2'h0;
			wb0_r <= 8'h00;
			wb1_r <= 8'h00;
			rd_ok_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ack_en_r <= ack_en_nxt;
			tx_en_r <= tx_en_nxt;
			tx_byte_r <= tx_byte_nxt;
			cmd_r <= cmd_nxt;
			wr_cnt_r <= wr_cnt_nxt;
			rd_idx_r <= rd_idx_nxt;
			wb0_r <= wb0_nxt;
			wb1_r <= wb1_nxt;
			rd_ok_r <= rd_ok_nxt;
		end
	end

	// Stored configuration
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pins_r <= `PUTC_RST_UNUSED_PINS;
			rlev_r <= `PUTC_RST_REMOTE_LEVEL;
			kick_r <= `PUTC_RST_KICK_LEAD;
			foff_r <= `PUTC_RST_FAST_OFF;
			pgpol_r <= `PUTC_RST_PGOOD_POL;
		end else begin
			pins_r <= pins_nxt;
			rlev_r <= rlev_nxt;
			kick_r <= kick_nxt;
			foff_r <= foff_nxt;
			pgpol_r <= pgpol_nxt;
		end
	end

	// Registered outputs
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			SDA_OUT <= 1'b0;
			AUX_OUT <= 8'h00;
			AUX_OE <= 8'h00;
			FUNC_IN <= 8'h00;
			PIN_UNUSED <= 8'h00;
			REMOTE_LEVEL <= 8'h00;
			KICK_LEAD_CODE <= 8'h00;
			KICK_LEAD_CYC <= `PUTC_KICK_CYC_W'(0);
			FAST_OFF_OFFSET <= 8'h00;
			PGOOD_PIN <= 1'b0;
		end else begin
			SDA_OUT <= 1'b0;
			AUX_OUT <= aux_out_nxt;
			AUX_OE <= aux_oe_nxt;
			FUNC_IN <= func_in_nxt;
			PIN_UNUSED <= util;
			REMOTE_LEVEL <= rlev_r;
			KICK_LEAD_CODE <= kick_r;
			KICK_LEAD_CYC <= kick_cyc_nxt;
			FAST_OFF_OFFSET <= foff_r;
			PGOOD_PIN <= pgood_nxt;
		end
	end

endmodule : putc_top

// File: sim/putc_top_properties.sv
// Port checker of the config bank
`include "putc_defines.svh"
module putc_top_properties (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic [7:0] AUX_IN,
	input wire logic [7:0] FUNC_OUT,
	input wire logic [7:0] FUNC_OE,
	input wire logic [7:0] AUX_OUT,
	input wire logic [7:0] AUX_OE,
	input wire logic [7:0] FUNC_IN,
	input wire logic [7:0] PIN_UNUSED,
	input wire logic [7:0] REMOTE_LEVEL,
	input wire logic [7:0] KICK_LEAD_CODE,
	input wire logic [10:0] KICK_LEAD_CYC,
	input wire logic [7:0] FAST_OFF_OFFSET,
	input wire logic PGOOD_STATE,
	input wire logic PGOOD_PIN
);
	logic st_r;
	wire logic pol_w = PGOOD_PIN ^ st_r;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) st_r <= 1'b0;
		else st_r <= PGOOD_STATE;
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);
	a_aux_out_mask: assert property ($past(RSTN) |->
		AUX_OUT == ($past(FUNC_OUT) & ~PIN_UNUSED)) else $error("aux out mask wrong");
	a_aux_oe_used: assert property ($past(RSTN) |->
		((AUX_OE ^ $past(FUNC_OE)) & ~PIN_UNUSED) == 8'h00) else $error("used pin oe wrong");
	a_func_in_mask: assert property ($past(RSTN) |->
		FUNC_IN == ($past(AUX_IN) & ~PIN_UNUSED)) else $error("func in mask wrong");
	a_kick_cycles: assert property ($past(RSTN) |-> KICK_LEAD_CYC == 11'((
		`PUTC_KICK_BASE_NS + `PUTC_KICK_STEP_NS * int'(KICK_LEAD_CODE))
		/ `PUTC_CLK_PERIOD_NS)) else $error("kick cycles wrong");
	a_regs_hold: assert property ($changed({REMOTE_LEVEL, KICK_LEAD_CODE,
		FAST_OFF_OFFSET, PIN_UNUSED}) |-> SCL_IN && SDA_IN && $past(SCL_IN, 2))
		else $error("register moved outside idle bus");
	a_pgood_track: assert property ($past(RSTN, 2) && $changed(pol_w) |->
		SCL_IN && SDA_IN) else $error("pgood stopped following state");
	a_unused_oe_hold: assert property (((AUX_OE ^ $past(AUX_OE)) & PIN_UNUSED
		& $past(PIN_UNUSED)) != 8'h00 |-> SCL_IN && SDA_IN) else $error("unused oe moved");
	a_sda_drive_low: assert property ($rose(SDA_OE) || $fell(SDA_OE) |->
		!SCL_IN) else $error("sda drive changed in high phase");
endmodule : putc_top_properties

bind putc_top putc_top_properties i_putc_top_properties (.*);

// File: sim/putc_host.sv
// Bus host model: bit-banged clock and data
module putc_host #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_m,
	output logic rd_stb,
	output logic [15:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// Phase length; raised for a slow host
	int half = 5;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		rd_stb = 1'b0;
		rd_data = 16'h0000;
	end
	task tick(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask : tick
	task start;
		sda_m = 1'b1;
		tick(half);
		scl = 1'b1;
		tick(half);
		sda_m = 1'b0;
		tick(half);
		scl = 1'b0;
	endtask : start
	// Long idle after stop lets the commit land
	task stop;
		tick(2);
		sda_m = 1'b0;
		tick(half);
		scl = 1'b1;
		tick(half);
		sda_m = 1'b1;
		tick(2 * half);
	endtask : stop
	task bitx(input logic b, output logic r);
		tick(2);
		sda_m = b;
		tick(half);
		scl = 1'b1;
		tick(half);
		r = sda;
		scl = 1'b0;
	endtask : bitx
	task put(input logic [7:0] b, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(b[i], r);
		bitx(1'b1, nak);
	endtask : put
	task get(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
		bitx(last, r);
	endtask : get
	task wr(input logic [6:0] a, input logic [7:0] c, input int n, input logic [15:0] d,
		output logic nak);
		logic k;
		start();
		put({a, 1'b0}, nak);
		put(c, k);
		nak = nak | k;
		for (int i = 0; i < n; i++) begin
			put(d[8 * i +: 8], k);
			nak = nak | k;
		end
		stop();
	endtask : wr
	task rd(input logic [7:0] c, input int n, output logic [15:0] d);
		logic k;
		logic [7:0] b;
		d = 16'hFFFF;
		start();
		put({ADDR, 1'b0}, k);
		put(c, k);
		start();
		put({ADDR, 1'b1}, k);
		for (int i = 0; i < n; i++) begin
			get(i == n - 1, b);
			d[8 * i +: 8] = b;
		end
		stop();
		rd_data = d;
		rd_stb = 1'b1;
		tick(1);
		rd_stb = 1'b0;
	endtask : rd
endmodule : putc_host

// File: sim/tb_top.sv
// Bench of the config bank: notes queued, matched by a monitor
`include "putc_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		string name;
		logic [15:0] exp;
	} putc_note_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] func_out = 8'h00;
	logic [7:0] func_oe = 8'h00;
	logic [7:0] aux_in = 8'h00;
	logic pg_st = 1'b0;
	logic pin_stb = 1'b0;
	logic [15:0] pin_v = 16'h0000;
	logic scl, sda_m, sda_w, sda_out, sda_oe, pg_pin, rd_stb, nak;
	logic [7:0] aux_out, aux_oe, func_in, unused, rlev, kcode, foff;
	logic [10:0] kcyc;
	logic [15:0] rd_data, rv;
	logic [15:0] sh[5];
	logic [7:0] cmds[5] = '{8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hD0};
	putc_note_t notes[$];
	int bad_count = 0;
	int checks = 0;
	assign sda_w = sda_m & ~(sda_oe & ~sda_out);
	always #50 clk = ~clk;
	putc_top i_putc_top (.CLK(clk), .RSTN(rst_n), .SCL_IN(scl), .SDA_IN(sda_w),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .AUX_IN(aux_in), .FUNC_OUT(func_out),
		.FUNC_OE(func_oe), .AUX_OUT(aux_out), .AUX_OE(aux_oe), .FUNC_IN(func_in),
		.PIN_UNUSED(unused), .REMOTE_LEVEL(rlev), .KICK_LEAD_CODE(kcode),
		.KICK_LEAD_CYC(kcyc), .FAST_OFF_OFFSET(foff), .PGOOD_STATE(pg_st), .PGOOD_PIN(pg_pin));
	putc_host i_putc_host (.clk(clk), .sda(sda_w), .scl(scl), .sda_m(sda_m),
		.rd_stb(rd_stb), .rd_data(rd_data));
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task note(input string name, input logic [15:0] exp);
		notes.push_back('{name, exp});
	endtask : note
	task automatic take(input logic [15:0] v);
		putc_note_t n;
		if (notes.size() > 0) n = notes.pop_front();
		check(n.name, v, n.exp);
	endtask : take
	always @(posedge clk) begin
		if (rd_stb === 1'b1) take(rd_data);
		if (pin_stb === 1'b1) take(pin_v);
	end
	task obs(input logic [15:0] v);
		pin_v = v;
		pin_stb = 1'b1;
		@(posedge clk);
		#10;
		pin_stb = 1'b0;
		// One idle edge so back-to-back observations never re-raise the strobe at once
		@(posedge clk);
		#10;
	endtask : obs
	task finish_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	task wb(input logic [6:0] a, input logic [7:0] c, input int n, input logic [15:0] d,
		input logic en);
		i_putc_host.wr(a, c, n, d, nak);
		note("nak", {15'h0000, en});
		obs({15'h0000, nak});
	endtask : wb
	// Two-byte reads: byte registers give 0xFF past their end
	task rall;
		for (int i = 0; i < 5; i++) begin
			note("read", (i == 0) ? sh[0] : {8'hFF, sh[i][7:0]});
			i_putc_host.rd(cmds[i], 2, rv);
		end
	endtask : rall
	task outs;
		logic [7:0] u, d;
		u = sh[0][7:0];
		d = sh[0][15:8];
		func_out = 8'($urandom);
		func_oe = 8'($urandom);
		aux_in = 8'($urandom) & ~(u & ~d);
		pg_st = 1'($urandom);
		repeat (2) @(posedge clk);
		#10;
		note("PIN_UNUSED", {8'h00, u});
		obs({8'h00, unused});
		note("AUX_OUT", {8'h00, func_out & ~u});
		obs({8'h00, aux_out});
		note("AUX_OE", {8'h00, (func_oe & ~u) | (d & u)});
		obs({8'h00, aux_oe});
		note("FUNC_IN", {8'h00, aux_in & ~u});
		obs({8'h00, func_in});
		note("REMOTE_LEVEL", sh[1]);
		obs({8'h00, rlev});
		note("KICK_LEAD_CODE", sh[2]);
		obs({8'h00, kcode});
		note("KICK_LEAD_CYC", 16'((`PUTC_KICK_BASE_NS + `PUTC_KICK_STEP_NS *
			int'(sh[2])) / `PUTC_CLK_PERIOD_NS));
		obs({5'h00, kcyc});
		note("FAST_OFF_OFFSET", sh[3]);
		obs({8'h00, foff});
		note("PGOOD_PIN", {15'h0000, pg_st ^ ~sh[4][0]});
		obs({15'h0000, pg_pin});
	endtask : outs
	task reset;
		rst_n = 1'b0;
		for (int i = 0; i < 5; i++) sh[i] = 16'h0000;
		repeat (3) @(posedge clk);
		#10;
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#10;
		rall();
		outs();
		$display("test reset done");
	endtask : reset
	initial begin
		void'($urandom(32'h575C1944));
		repeat (17) @(posedge clk);
		reset();
		for (int i = 1; i < 5; i++) begin
			sh[i] = {8'h00, 8'($urandom)};
			wb(7'h2A, cmds[i], 1, sh[i], 1'b0);
		end
		rall();
		rall();
		outs();
		for (int k = 0; k < 2; k++) begin
			sh[2] = k ? 16'h00FF : 16'h0000;
			wb(7'h2A, 8'hC7, 1, sh[2], 1'b0);
			outs();
		end
		$display("test bytes done");
		for (int i = 0; i < 8; i++) begin
			sh[0] = {8'($urandom), 8'h01 << i};
			wb(7'h2A, 8'hC5, 2, sh[0], 1'b0);
			outs();
		end
		sh[0] = 16'($urandom);
		wb(7'h2A, 8'hC5, 2, sh[0], 1'b0);
		rall();
		outs();
		$display("test pins done");
		for (int i = 0; i < 4; i++) begin
			sh[4] = {8'h00, 8'(i * 8'h55)};
			wb(7'h2A, 8'hD0, 1, sh[4], 1'b0);
			outs();
		end
		$display("test polarity done");
		i_putc_host.half = 9;
		wb(7'h2A, 8'hC5, 1, 16'h00A5, 1'b0);
		wb(7'h2A, 8'hC6, 2, 16'h1234, 1'b1);
		wb(7'h2A, 8'hC9, 1, 16'h0011, 1'b1);
		wb(7'h2B, 8'hC6, 1, 16'h0077, 1'b1);
		// Read address with no command byte before it must be refused
		i_putc_host.start();
		i_putc_host.put(8'h55, nak);
		i_putc_host.stop();
		note("nak", 16'h0001);
		obs({15'h0000, nak});
		rall();
		i_putc_host.half = 5;
		$display("test refuse done");
		reset();
		for (int i = 0; i < 50 && notes.size() > 0; i++) @(posedge clk);
		if (notes.size() > 0) bad_count++;
		finish_test();
	end
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		finish_test();
	end
endmodule : tb_top
